/* File: pkg/bpg_pkg.sv */
`default_nettype none
package bpg_pkg;
  typedef struct packed {
    logic        quasi_random_fixed_enable;
    logic        pattern_type_select;
    logic [4:0]  tap_stage_select;
    logic [4:0]  length_stage_select;
    logic [31:0] seed_pattern_value;
  } bpg_pat_cfg_t;

  typedef struct packed {
    logic [31:0] state;
    logic        bit_out;
  } bpg_gen_step_t;

  typedef enum logic {BPG_HUNT, BPG_SYNC} bpg_chk_state_t;
endpackage
`default_nettype wire

/* File: pkg/bpg_regs.svh */
`ifndef BPG_REGS_SVH
`define BPG_REGS_SVH
// register indices; byte address is four times the index
`define BPG_IDX_CONTROL       8'h50
`define BPG_IDX_PATTERN_CFG   8'h52
`define BPG_IDX_SEED_LOW      8'h54
`define BPG_IDX_SEED_HIGH     8'h56
`define BPG_IDX_ERR_INSERT    8'h58
`define BPG_IDX_STATUS        8'h5C
`define BPG_IDX_STATUS_LATCH  8'h5E
`define BPG_IDX_IRQ_ENABLE    8'h60
`define BPG_IDX_ERRCNT_LOW    8'h64
`define BPG_IDX_ERRCNT_HIGH   8'h66
`define BPG_IDX_BITCNT_LOW    8'h68
`define BPG_IDX_BITCNT_HIGH   8'h6A
// control bits
`define BPG_CR_SRC_SEL        7
`define BPG_CR_LOCAL_REQ      6
`define BPG_CR_RX_LOAD        5
`define BPG_CR_RX_INVERT      4
`define BPG_CR_MANUAL_RESYNC  3
`define BPG_CR_AUTO_DISABLE   2
`define BPG_CR_TX_LOAD        1
`define BPG_CR_TX_INVERT      0
// pattern config fields
`define BPG_PC_TAP_HI         12
`define BPG_PC_TAP_LO         8
`define BPG_PC_QR_ENABLE      6
`define BPG_PC_TYPE           5
`define BPG_PC_LEN_HI         4
`define BPG_PC_LEN_LO         0
// status and latched status bits
`define BPG_SR_DONE           3
`define BPG_SR_ERR_NONZERO    1
`define BPG_SR_OOS            0
`define BPG_SL_BIT_ERROR      2
`define BPG_SL_ERR_NONZERO    1
`define BPG_SL_OOS_CHANGE     0
// fixed quasi-random pattern: stage 20 and tap 17, zero run of 14
`define BPG_QR_LEN_IDX        5'h13
`define BPG_QR_TAP_IDX        5'h10
`define BPG_QR_ZERO_RUN       14
// register reset value and checker constants
`define BPG_REG_RESET         16'h0000
`define BPG_SYNC_MATCHES      6'h20
`define BPG_WINDOW_LAST       6'h3F
`define BPG_RESYNC_ERRORS     3'h6
`endif

/* File: sim/bert_pattern_gen_check_tb.sv */
`default_nettype none
`include "bpg_regs.svh"
module bert_pattern_gen_check_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in, rst_n_in, psel, penable, pwrite, ext_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, a_bc, a_ec, b_bc, b_ec;
  logic        pready, pslverr, lclk, rx_data, tx_data, oos, last_err, ok;
  logic [15:0] ctrl;
  int          n_fail, checks_done, i, ones, run, mx;

  initial begin
    mclk_in = 0; rst_n_in = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; ext_req = 0; ctrl = 0; n_fail = 0; checks_done = 0;
  end
  always #2 mclk_in = ~mclk_in;

  bpg_bert dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .external_snapshot_request_in(ext_req), .tx_line_clock_in(lclk),
    .rx_line_clock_in(lclk), .rx_data_in(rx_data), .tx_data_out(tx_data),
    .out_of_sync_out(oos));
  bpg_line_model part_u (.tx_data_in(tx_data), .line_clock_out(lclk), .rx_data_out(rx_data));
  ////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    @(posedge mclk_in);
    psel <= 1; penable <= 0; pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00}; pwdata <= {16'h0000, d};
    @(posedge mclk_in);
    penable <= 1;
    // no wait count is assumed; a slave that never answers trips the watchdog
    do @(posedge mclk_in); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task automatic wc(input logic [15:0] v);
    ctrl = v;
    apb(1'b1, `BPG_IDX_CONTROL, v);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 16'h0000);
  endtask

  task automatic wait_oos(input logic v, input int lim, input string nm);
    int n;
    for (n = 0; n < lim && oos !== v; n++) @(posedge mclk_in);
    chk(nm, v, oos);
  endtask

  // skip the bits around a reload before capturing
  task automatic grab(input int n);
    int w;
    repeat (60) @(posedge mclk_in);
    part_u.cap.delete();
    for (w = 0; w < n * 12 && part_u.cap.size() < n; w++) @(posedge mclk_in);
    chk("capture_length", 1, part_u.cap.size() >= n);
  endtask

  // phase after a load is not fixed, so any rotation of the pattern is accepted
  function automatic logic rot_ok(input logic [31:0] p);
    int r, b;
    logic hit;
    rot_ok = 1'b0;
    for (r = 0; r < 32; r++) begin
      hit = 1'b1;
      for (b = 0; b < 64; b++) if (part_u.cap[b] !== p[31 - ((b + r) % 32)]) hit = 1'b0;
      if (hit) rot_ok = 1'b1;
    end
  endfunction

  task automatic snap(input logic ext, output logic [31:0] bc, output logic [31:0] ec);
    int n;
    logic [31:0] t;
    if (ext) ext_req <= 1'b1; else wc(ctrl | 16'h0040);
    for (n = 0; n < 20; n++) begin
      rd(`BPG_IDX_STATUS);
      if (q[`BPG_SR_DONE] === 1'b1) break;
    end
    chk("snapshot_done", 1, q[`BPG_SR_DONE]);
    rd(`BPG_IDX_BITCNT_HIGH); t = q;
    rd(`BPG_IDX_BITCNT_LOW); bc = {t[15:0], q[15:0]};
    rd(`BPG_IDX_ERRCNT_HIGH); t = q;
    rd(`BPG_IDX_ERRCNT_LOW); ec = {t[15:0], q[15:0]};
    if (ext) ext_req <= 1'b0; else wc(ctrl & 16'hFFBF);
    repeat (4) @(posedge mclk_in);
    rd(`BPG_IDX_STATUS);
    chk("done_cleared", 0, q[`BPG_SR_DONE]);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1;
    rd(`BPG_IDX_CONTROL); chk("control_reset", 0, q);
    rd(`BPG_IDX_PATTERN_CFG); chk("pattern_cfg_reset", 0, q);
    rd(`BPG_IDX_STATUS); chk("status_oos", 1, q[`BPG_SR_OOS]);
    rd(8'h5A); chk("unmapped_error", 1, last_err);
    apb(1'b1, `BPG_IDX_SEED_HIGH, 16'hA5C3);
    apb(1'b1, `BPG_IDX_SEED_LOW, 16'h0F1E);
    apb(1'b1, `BPG_IDX_PATTERN_CFG, 16'h003F);
    rd(`BPG_IDX_SEED_HIGH); chk("seed_high", 32'h0000A5C3, q);
    wc(16'h0002);
    grab(64); chk("tx_repeat", 1, rot_ok(32'hA5C30F1E));
    wc(16'h0003); grab(64); chk("tx_invert", 1, rot_ok(~32'hA5C30F1E));
    wc(16'h0002);
    wc(16'h0022); wait_oos(0, 3000, "rx_sync");
    wc(16'h002A); wait_oos(1, 100, "manual_resync");
    wait_oos(0, 3000, "resync_done");
    wc(16'h0002); wc(16'h0022); wait_oos(1, 100, "rx_load_resync");
    wait_oos(0, 3000, "rx_resync2");
    repeat (2000) @(posedge mclk_in);
    snap(0, a_bc, a_ec); chk("err_count_clean", 0, a_ec);
    repeat (200) @(posedge mclk_in);
    snap(0, b_bc, b_ec); chk("count_cleared", 1, b_bc != 0 && b_bc < a_bc);
    wc(16'h00A2); snap(1, a_bc, a_ec); chk("ext_count", 1, a_bc != 0);
    wc(16'h0022);
    ext_req <= 1'b1;
    repeat (4) @(posedge mclk_in);
    // switching the source onto a high request must itself snapshot
    wc(16'h00A2);
    rd(`BPG_IDX_STATUS);
    chk("source_switch_snapshot", 1, q[`BPG_SR_DONE]);
    ext_req <= 1'b0;
    wc(16'h0022);
    part_u.err_every = 16;
    repeat (2000) @(posedge mclk_in);
    chk("sparse_errors", 0, oos);
    snap(0, a_bc, a_ec); chk("errors_counted", 1, a_ec != 0);
    wc(16'h0026); part_u.err_every = 4;
    repeat (2000) @(posedge mclk_in);
    chk("auto_disabled", 0, oos);
    wc(16'h0022); wait_oos(1, 1000, "auto_resync");
    part_u.err_every = 0;
    apb(1'b1, `BPG_IDX_PATTERN_CFG, 16'h0506);
    wc(16'h0000); wc(16'h0002); grab(254);
    ok = 1; ones = 0;
    for (i = 0; i < 127; i++) begin
      if (part_u.cap[i] !== part_u.cap[i + 127]) ok = 0;
      if (part_u.cap[i] === 1'b1) ones++;
    end
    chk("prbs_period", 1, ok);
    chk("prbs_ones", 64, ones);
    part_u.inv = 1; wc(16'h0022);
    repeat (3000) @(posedge mclk_in);
    chk("no_sync_inverted", 1, oos);
    wc(16'h0032); wait_oos(0, 3000, "rx_invert_sync");
    part_u.inv = 0;
    apb(1'b1, `BPG_IDX_PATTERN_CFG, 16'h0040);
    wc(16'h0000); wc(16'h0002); grab(400);
    run = 0; mx = 0; ones = 0;
    for (i = 0; i < 400; i++) begin
      if (part_u.cap[i] === 1'b1) begin ones++; run = 0; end else run++;
      if (run > mx) mx = run;
    end
    chk("fixed_prbs_zero_run", 1, mx <= `BPG_QR_ZERO_RUN && ones > 0);
    complete_run;
  end

  // whole sequence is about 19k mclk; the 50k mclk limit is well over twice that, so reaching it means a hang
  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
endmodule // bert_pattern_gen_check_tb
`default_nettype wire

/* File: sim/bpg_line_model.sv */
`default_nettype none
module bpg_line_model (
  input  wire logic tx_data_in,
  output logic      line_clock_out,
  output logic      rx_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv;
  int   err_every;
  int   k;
  logic cap[$];

  initial begin
    line_clock_out = 1'b0;
    rx_data_out = 1'b0;
    inv = 1'b0;
    err_every = 0;
    k = 0;
  end
  ////////////////////////////////////////////////////////////
  // free running line clock, odd half period so its phase drifts against mclk
  always #17.3 line_clock_out = ~line_clock_out;
  // sample mid-bit: tx settles a few mclk after the rise
  always @(negedge line_clock_out) begin
    cap.push_back(tx_data_in);
    k <= k + 1;
    rx_data_out <= tx_data_in ^ inv ^ (err_every != 0 && k % err_every == 0);
  end
endmodule // bpg_line_model
`default_nettype wire

/* File: verilog/bpg_bert.sv */
// Register access over APB was decided locally.
`default_nettype none
`include "bpg_regs.svh"
module bpg_bert
  import bpg_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  input  wire logic              external_snapshot_request_in,
  input  wire logic              tx_line_clock_in,
  input  wire logic              rx_line_clock_in,
  input  wire logic              rx_data_in,
  output logic                   tx_data_out,
  output logic                   out_of_sync_out
);

  // the highest index needs nine byte address bits; the check asks for at least ten
  if (ADDR_W < 10) begin : g_addr_w_check
    $error("bpg_bert: ADDR_W must reach index 6Ah");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    addr_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // one generator step; stage index equals field, i.e. stage number minus one
  function automatic bpg_gen_step_t gen_step(input bpg_pat_cfg_t c, input logic [31:0] g);
    logic [4:0] n;
    logic [4:0] y;
    logic       use_tap;
    n = c.quasi_random_fixed_enable ? `BPG_QR_LEN_IDX : c.length_stage_select;
    y = c.quasi_random_fixed_enable ? `BPG_QR_TAP_IDX : c.tap_stage_select;
    use_tap = c.quasi_random_fixed_enable | ~c.pattern_type_select;
    gen_step.state   = {g[30:0], g[n] ^ (use_tap & g[y])};
    gen_step.bit_out = g[n] | (c.quasi_random_fixed_enable &
                       (g[`BPG_QR_LEN_IDX -: `BPG_QR_ZERO_RUN] == '0));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] tx_clk_s;
  logic [2:0] rx_clk_s;
  logic [1:0] rx_dat_s;
  logic [1:0] ext_req_s;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_clk_s  <= '0;
      rx_clk_s  <= '0;
      rx_dat_s  <= '0;
      ext_req_s <= '0;
    end else begin
      tx_clk_s  <= {tx_clk_s[1:0], tx_line_clock_in};
      rx_clk_s  <= {rx_clk_s[1:0], rx_line_clock_in};
      rx_dat_s  <= {rx_dat_s[0], rx_data_in};
      ext_req_s <= {ext_req_s[0], external_snapshot_request_in};
    end
  end
  // line clocks must stay below half of mclk; rising edges become ticks
  logic tx_tick;
  logic rx_tick;
  assign tx_tick = tx_clk_s[1] & ~tx_clk_s[2];
  assign rx_tick = rx_clk_s[1] & ~rx_clk_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // apb slave and registers

  logic [15:0] ctrl;
  logic [15:0] pcfg;
  logic [15:0] seed_lo;
  logic [15:0] seed_hi;
  logic [15:0] err_ins;
  logic [15:0] irq_en;
  logic [2:0]  stat_latch;
  logic [31:0] err_snap;
  logic [31:0] bit_snap;
  logic        snap_done;
  logic        active_req;
  logic        chk_sync;
  logic        wr_en;
  logic [31:0] next_rdata;
  logic        next_err;

  assign wr_en = psel_in & penable_in & pwrite_in & pready_out;

  always_comb begin
    next_rdata = '0;
    next_err   = 1'b0;
    if      (addr_hit(paddr_in, `BPG_IDX_CONTROL))      next_rdata[15:0] = ctrl;
    else if (addr_hit(paddr_in, `BPG_IDX_PATTERN_CFG))  next_rdata[15:0] = pcfg;
    else if (addr_hit(paddr_in, `BPG_IDX_SEED_LOW))     next_rdata[15:0] = seed_lo;
    else if (addr_hit(paddr_in, `BPG_IDX_SEED_HIGH))    next_rdata[15:0] = seed_hi;
    else if (addr_hit(paddr_in, `BPG_IDX_ERR_INSERT))   next_rdata[15:0] = err_ins;
    else if (addr_hit(paddr_in, `BPG_IDX_STATUS)) begin
      // done is masked by the live request so a fallen request reads clear
      next_rdata[`BPG_SR_DONE]        = snap_done & active_req;
      next_rdata[`BPG_SR_ERR_NONZERO] = (err_snap != '0);
      next_rdata[`BPG_SR_OOS]         = ~chk_sync;
    end
    else if (addr_hit(paddr_in, `BPG_IDX_STATUS_LATCH)) next_rdata[2:0]  = stat_latch;
    else if (addr_hit(paddr_in, `BPG_IDX_IRQ_ENABLE))   next_rdata[15:0] = irq_en;
    else if (addr_hit(paddr_in, `BPG_IDX_ERRCNT_LOW))   next_rdata[15:0] = err_snap[15:0];
    else if (addr_hit(paddr_in, `BPG_IDX_ERRCNT_HIGH))  next_rdata[15:0] = err_snap[31:16];
    else if (addr_hit(paddr_in, `BPG_IDX_BITCNT_LOW))   next_rdata[15:0] = bit_snap[15:0];
    else if (addr_hit(paddr_in, `BPG_IDX_BITCNT_HIGH))  next_rdata[15:0] = bit_snap[31:16];
    else next_err = 1'b1;
  end

  // answer is prepared in the setup cycle, so every access takes one cycle
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & next_err;
      prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? next_rdata : '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl    <= `BPG_REG_RESET;
      pcfg    <= `BPG_REG_RESET;
      seed_lo <= `BPG_REG_RESET;
      seed_hi <= `BPG_REG_RESET;
      err_ins <= `BPG_REG_RESET;
      irq_en  <= `BPG_REG_RESET;
    end else if (wr_en && !pslverr_out) begin
      if (addr_hit(paddr_in, `BPG_IDX_CONTROL))     ctrl    <= pwdata_in[15:0];
      if (addr_hit(paddr_in, `BPG_IDX_PATTERN_CFG)) pcfg    <= pwdata_in[15:0];
      if (addr_hit(paddr_in, `BPG_IDX_SEED_LOW))    seed_lo <= pwdata_in[15:0];
      if (addr_hit(paddr_in, `BPG_IDX_SEED_HIGH))   seed_hi <= pwdata_in[15:0];
      if (addr_hit(paddr_in, `BPG_IDX_ERR_INSERT))  err_ins <= pwdata_in[15:0];
      if (addr_hit(paddr_in, `BPG_IDX_IRQ_ENABLE))  irq_en  <= pwdata_in[15:0];
    end
  end

  bpg_pat_cfg_t prog_cfg;
  assign prog_cfg = '{quasi_random_fixed_enable: pcfg[`BPG_PC_QR_ENABLE],
                      pattern_type_select: pcfg[`BPG_PC_TYPE],
                      tap_stage_select:    pcfg[`BPG_PC_TAP_HI:`BPG_PC_TAP_LO],
                      length_stage_select: pcfg[`BPG_PC_LEN_HI:`BPG_PC_LEN_LO],
                      seed_pattern_value:  {seed_hi, seed_lo}};

  // control edges; a bit must fall before it can fire again
  logic [7:0] ctrl_q;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) ctrl_q <= '0;
    else           ctrl_q <= ctrl[7:0];
  end
  logic rx_load_rise;
  logic tx_load_rise;
  logic resync_rise;
  assign rx_load_rise = ctrl[`BPG_CR_RX_LOAD] & ~ctrl_q[`BPG_CR_RX_LOAD];
  assign tx_load_rise = ctrl[`BPG_CR_TX_LOAD] & ~ctrl_q[`BPG_CR_TX_LOAD];
  assign resync_rise  = ctrl[`BPG_CR_MANUAL_RESYNC] & ~ctrl_q[`BPG_CR_MANUAL_RESYNC];

  ////////////////////////////////////////////////////////////////////////////
  // transmit generator

  bpg_pat_cfg_t  tx_cfg;
  logic [31:0]   tx_gen;
  bpg_gen_step_t tx_step;
  assign tx_step = gen_step(tx_cfg, tx_gen);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tx_cfg      <= '0;
      tx_gen      <= '0;
      tx_data_out <= 1'b0;
    end else if (tx_load_rise) begin
      tx_cfg <= prog_cfg;
      tx_gen <= prog_cfg.seed_pattern_value;
    end else if (tx_tick) begin
      tx_gen      <= tx_step.state;
      tx_data_out <= tx_step.bit_out ^ ctrl[`BPG_CR_TX_INVERT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive generator and checker

  bpg_pat_cfg_t   rx_cfg;
  logic [31:0]    rx_gen;
  bpg_gen_step_t  rx_step;
  bpg_chk_state_t chk_state;
  logic [5:0]     match_cnt;
  logic [5:0]     win_pos;
  logic [2:0]     win_errs;
  logic           rx_bit;
  logic           mismatch;
  logic           err_burst;
  assign rx_step   = gen_step(rx_cfg, rx_gen);
  assign rx_bit    = rx_dat_s[1] ^ ctrl[`BPG_CR_RX_INVERT];
  // the register holds bit history, so the prediction is the feedback bit in hunt and
  // sync alike; forced ones of the fixed pattern are not predicted and count as errors
  assign mismatch  = rx_bit ^ rx_step.state[0];
  assign chk_sync  = (chk_state == BPG_SYNC);
  assign err_burst = rx_tick & chk_sync & mismatch & (win_errs == `BPG_RESYNC_ERRORS - 3'h1);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rx_cfg    <= '0;
      rx_gen    <= '0;
      chk_state <= BPG_HUNT;
      match_cnt <= '0;
      win_pos   <= '0;
      win_errs  <= '0;
    end else if (rx_load_rise || resync_rise) begin
      if (rx_load_rise) begin
        rx_cfg <= prog_cfg;
        rx_gen <= prog_cfg.seed_pattern_value;
      end
      chk_state <= BPG_HUNT;
      match_cnt <= '0;
    end else if (rx_tick) begin
      case (chk_state)
        BPG_HUNT: begin
          // self-seeding: received bits fill the generator until it predicts them
          rx_gen    <= {rx_gen[30:0], rx_bit};
          match_cnt <= mismatch ? 6'h0 : match_cnt + 6'h1;
          win_pos   <= '0;
          win_errs  <= '0;
          if (!mismatch && match_cnt == `BPG_SYNC_MATCHES - 6'h1) chk_state <= BPG_SYNC;
        end
        BPG_SYNC: begin
          rx_gen  <= rx_step.state;
          win_pos <= win_pos + 6'h1;
          if (win_pos == `BPG_WINDOW_LAST) win_errs <= '0;
          else if (mismatch && win_errs != `BPG_RESYNC_ERRORS) win_errs <= win_errs + 3'h1;
          if (err_burst && !ctrl[`BPG_CR_AUTO_DISABLE]) begin
            chk_state <= BPG_HUNT;
            match_cnt <= '0;
          end
        end
        default: chk_state <= BPG_HUNT;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) out_of_sync_out <= 1'b1;
    else           out_of_sync_out <= ~chk_sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and snapshot

  logic        active_req_q;
  logic        snap_fire;
  logic        bit_inc;
  logic        err_inc;
  logic [31:0] bit_run;
  logic [31:0] err_run;
  logic        sync_q;
  // switching source with a request high looks like an edge and snapshots
  assign active_req = ctrl[`BPG_CR_SRC_SEL] ? ext_req_s[1] : ctrl[`BPG_CR_LOCAL_REQ];
  assign snap_fire  = active_req & ~active_req_q;
  assign bit_inc    = rx_tick & chk_sync;
  assign err_inc    = bit_inc & mismatch;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      active_req_q <= 1'b0;
      bit_run      <= '0;
      err_run      <= '0;
      bit_snap     <= '0;
      err_snap     <= '0;
    end else begin
      active_req_q <= active_req;
      if (snap_fire) begin
        bit_snap <= bit_run;
        err_snap <= err_run;
        bit_run  <= {31'h0, bit_inc};
        err_run  <= {31'h0, err_inc};
      end else begin
        if (bit_inc) bit_run <= bit_run + 32'h1;
        if (err_inc) err_run <= err_run + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in)        snap_done <= 1'b0;
    else if (!active_req) snap_done <= 1'b0;
    else if (snap_fire)   snap_done <= 1'b1;
  end

  // latched status: hardware set wins over a same-cycle write-one clear
  logic [2:0] lat_set;
  logic [2:0] lat_clr;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) sync_q <= 1'b0;
    else           sync_q <= chk_sync;
  end
  assign lat_set[`BPG_SL_BIT_ERROR]   = err_inc;
  assign lat_set[`BPG_SL_ERR_NONZERO] = err_inc & (snap_fire | err_run == '0);
  assign lat_set[`BPG_SL_OOS_CHANGE]  = chk_sync ^ sync_q;
  assign lat_clr = (wr_en && addr_hit(paddr_in, `BPG_IDX_STATUS_LATCH)) ? pwdata_in[2:0] : 3'h0;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) stat_latch <= '0;
    else           stat_latch <= (stat_latch & ~lat_clr) | lat_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_snap_copy;
    @(posedge mclk_in) disable iff (!rst_n_in)
      snap_fire |=> (bit_snap == $past(bit_run)) && (err_snap == $past(err_run));
  endproperty
  a_snap_copy: assert property (p_snap_copy) else $error("snapshot copy wrong");

  property p_restart_one;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (snap_fire && err_inc) |=> (err_run == 32'h1) && stat_latch[`BPG_SL_ERR_NONZERO];
  endproperty
  a_restart_one: assert property (p_restart_one) else $error("counter not restarted at one");

  property p_done_clear;
    @(posedge mclk_in) disable iff (!rst_n_in)
      !active_req |=> !snap_done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag stuck");

  property p_rx_load;
    @(posedge mclk_in) disable iff (!rst_n_in)
      rx_load_rise |=> (rx_cfg == $past(prog_cfg)) && !chk_sync;
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx load failed");

  property p_tx_load;
    @(posedge mclk_in) disable iff (!rst_n_in)
      tx_load_rise |=> tx_gen == $past(prog_cfg.seed_pattern_value);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx load failed");

  property p_manual_resync;
    @(posedge mclk_in) disable iff (!rst_n_in)
      resync_rise |=> !chk_sync ##1 (match_cnt <= 6'h1);
  endproperty
  a_manual_resync: assert property (p_manual_resync) else $error("manual resync ignored");

  property p_auto_resync;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (err_burst && !ctrl[`BPG_CR_AUTO_DISABLE] && !rx_load_rise && !resync_rise)
        |=> !chk_sync;
  endproperty
  a_auto_resync: assert property (p_auto_resync) else $error("no resync on errors");

  property p_hold_sync;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (chk_sync && ctrl[`BPG_CR_AUTO_DISABLE] && !rx_load_rise && !resync_rise) |=> chk_sync;
  endproperty
  a_hold_sync: assert property (p_hold_sync) else $error("left sync while disabled");

  property p_tx_invert;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (tx_tick && !tx_load_rise) |=>
        tx_data_out == ($past(tx_step.bit_out) ^ $past(ctrl[`BPG_CR_TX_INVERT]));
  endproperty
  a_tx_invert: assert property (p_tx_invert) else $error("tx inversion wrong");

  property p_count_sync;
    @(posedge mclk_in) disable iff (!rst_n_in)
      (!chk_sync && !snap_fire) |=> $stable(bit_run) && $stable(err_run);
  endproperty
  a_count_sync: assert property (p_count_sync) else $error("counted out of sync");

endmodule // bpg_bert
`default_nettype wire
